/* File: fawp_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Array engine stand-in, applies each op pulse
module fawp_array_model
    import fawp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              op_valid,
    input  wire logic [2:0]        op_kind,
    input  wire logic [ADDR_W-1:0] op_addr,
    input  wire logic [7:0]        op_data
);
    logic [7:0] mem [int]; // Sparse, absent bytes read as erased
    // Program only clears bits; erase drops all, a coarse stand-in
    always @(posedge sys_clk) begin
        if (op_valid === 1'b1 && op_kind === K_PROG) begin
            mem[op_addr] = (mem.exists(op_addr) ? mem[op_addr]
                            : ERASED_BYTE) & op_data;
        end else if (op_valid === 1'b1) begin
            mem.delete();
        end
    end
endmodule
`default_nettype wire

/* File: fawp_pkg.sv */
// Notes on behaviour
// - Program only clears bits; pages independent.
// - Erase sets bits; never per page.
// - 64MB as 1024 sectors of sixteen 4KB.
// - Linear addresses, top byte 03FFFFFFh.
// - Two dies, each two 128Mb segments.
// - 64 OTP bytes outside main array.
// - Discard modify commands with partial bytes.
// - Write enable latch required before modifying.
// - No modification before power-on timer ends.
// - Sector write-lock bit refuses program/erase.
// - Lock-down freezes write-lock until reset.
// - Lock write refused while lock-down set.
// - Top mode: code picks topmost sectors.
// - Bottom mode: code picks lowest sectors.
// - Write-protect pin locks block-protect bits.
`timescale 1ns/1ps
`default_nettype none
package fawp_pkg;
    // Clock and power-on timing
    localparam int SYS_CLK_MHZ = 10;
    localparam int POR_TIME_US = 1000;
    // Array geometry
    localparam int ADDR_W      = 26;
    localparam logic [31:0] ARRAY_LAST = 32'h03FF_FFFF; // Top byte address
    localparam int SECTOR_W    = 10;
    localparam int SECTOR_LSB  = 16;
    localparam int SUBSEC_LSB  = 12;
    localparam int DIE_BIT     = 25;
    localparam int SEG_BIT     = 24;
    localparam int SCAN_W      = 9;
    localparam logic [SCAN_W-1:0] SCAN_LAST = 9'h1FF;
    localparam int OTP_BYTES   = 64;
    localparam int OTP_W       = 6;
    localparam logic [10:0] SECTOR_SPAN_ALL = 11'h400;
    localparam logic [3:0]  BP_CODE_MAX     = 4'hA;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    // Register byte offsets
    localparam logic [4:0] OFF_ADDR   = 5'h00;
    localparam logic [4:0] OFF_DATA   = 5'h04;
    localparam logic [4:0] OFF_PULSES = 5'h08;
    localparam logic [4:0] OFF_CMD    = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;
    localparam logic [4:0] OFF_PROT   = 5'h14;
    localparam logic [4:0] OFF_LOCKRD = 5'h18;
    localparam logic [4:0] OFF_OTPRD  = 5'h1C;
    // Command codes
    localparam logic [3:0] CMD_WREN   = 4'h1;
    localparam logic [3:0] CMD_WRDI   = 4'h2;
    localparam logic [3:0] CMD_PROG   = 4'h3;
    localparam logic [3:0] CMD_SSE    = 4'h4;
    localparam logic [3:0] CMD_SE     = 4'h5;
    localparam logic [3:0] CMD_DIE    = 4'h6;
    localparam logic [3:0] CMD_PGE    = 4'h7;
    localparam logic [3:0] CMD_WRSR   = 4'h8;
    localparam logic [3:0] CMD_WRLR   = 4'h9;
    localparam logic [3:0] CMD_OTP    = 4'hA;
    // Array engine operation kinds
    localparam logic [2:0] K_NONE = 3'h0;
    localparam logic [2:0] K_PROG = 3'h1;
    localparam logic [2:0] K_SSE  = 3'h2;
    localparam logic [2:0] K_SE   = 3'h3;
    localparam logic [2:0] K_DIE  = 3'h4;
    // Refusal reasons, in priority order
    localparam logic [3:0] R_NONE  = 4'h0;
    localparam logic [3:0] R_POR   = 4'h1;
    localparam logic [3:0] R_FRAME = 4'h2;
    localparam logic [3:0] R_WEL   = 4'h3;
    localparam logic [3:0] R_PAGE  = 4'h4;
    localparam logic [3:0] R_RANGE = 4'h5;
    localparam logic [3:0] R_PROT  = 4'h6;
    localparam logic [3:0] R_LOCKD = 4'h7;
    localparam logic [3:0] R_WP    = 4'h8;
    // Reset values
    localparam logic [4:0] PROT_RESET = 5'h00;
endpackage

module fawp_range_dec
    import fawp_pkg::*;
(
    input  wire logic                top_bottom,
    input  wire logic                protect_size_bit3,
    input  wire logic                protect_size_bit2,
    input  wire logic                protect_size_bit1,
    input  wire logic                protect_size_bit0,
    input  wire logic [SECTOR_W-1:0] sector,
    output logic                     protected_hit
);
    logic [3:0]  code;  // Block-protect code
    logic [10:0] span;  // Number of sectors covered
    logic [10:0] sec_x; // Sector widened for compare

    assign code = {protect_size_bit3, protect_size_bit2,
                   protect_size_bit1, protect_size_bit0};
    // Zero covers nothing, above ten covers all, else a power of two
    assign span = (code == 4'h0) ? 11'h000 :
                  (code > BP_CODE_MAX) ? SECTOR_SPAN_ALL :
                  (11'h001 << (code - 4'h1));
    assign sec_x = {1'b0, sector};
    // Bottom counts up from sector 0, top counts down from the last
    assign protected_hit = top_bottom ? (sec_x < span) :
                           (sec_x >= (SECTOR_SPAN_ALL - span));
endmodule
`default_nettype wire

/* File: fawp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fawp_top
    import fawp_pkg::*;
#(
    parameter int POR_CYCLES = POR_TIME_US * SYS_CLK_MHZ
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              wp_n,
    output logic                   op_valid,
    output logic      [2:0]        op_kind,
    output logic      [ADDR_W-1:0] op_addr,
    output logic      [7:0]        op_data
);
    localparam int POR_W = $clog2(POR_CYCLES + 1);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_SCAN  = 2'b10
    } fawp_state_t;

    fawp_state_t       state_q;      // Command sequencer
    logic              wait_q;       // Waitrequest flop
    logic [31:0]       rdata_q;      // Read data flop
    logic [31:0]       addr_q;       // Target address
    logic [7:0]        data_q;       // Program or register data
    logic [15:0]       pulses_q;     // Clock pulses seen in frame
    logic [3:0]        cmd_q;        // Last command code
    logic              wel_q;        // Write enable latch
    logic [POR_W-1:0]  por_cnt_q;    // Power-on timer
    logic              por_done_q;   // Supply judged valid
    logic [2:0]        wp_s_q;       // Pin synchroniser
    logic              wp_low_q;     // Filtered pin level low
    logic [4:0]        prot_q;       // Top/bottom and code
    logic [1023:0]     wl_q;         // Sector write-lock bits
    logic [1023:0]     ld_q;         // Sector lock-down bits
    logic [7:0]        otp_q [OTP_BYTES]; // One-time area
    logic [SCAN_W-1:0] scan_cnt_q;   // Die erase scan position
    logic              scan_die_q;   // Die under scan
    logic              ok_q;         // Last command executed
    logic              refused_q;    // Last command refused
    logic [3:0]        reason_q;     // Why it was refused
    logic              op_valid_q;
    logic [2:0]        op_kind_q;
    logic [ADDR_W-1:0] op_addr_q;
    logic [7:0]        op_data_q;

    // Bus decode
    wire bus_req  = avs_read | avs_write;
    wire bus_take = bus_req & ~wait_q;
    wire wr_take  = bus_take & avs_write;
    wire wr_addr  = wr_take & (avs_address == OFF_ADDR);
    wire wr_data  = wr_take & (avs_address == OFF_DATA);
    wire wr_puls  = wr_take & (avs_address == OFF_PULSES);
    wire wr_cmd   = wr_take & (avs_address == OFF_CMD);

    // Target decode: sector, die, segment, range and OTP index
    wire [SECTOR_W-1:0] tgt_sec = addr_q[DIE_BIT:SECTOR_LSB];
    wire                tgt_die = addr_q[DIE_BIT];
    wire                tgt_seg = addr_q[SEG_BIT];
    wire                tgt_out = (addr_q > ARRAY_LAST);
    wire [OTP_W-1:0]    otp_idx = addr_q[OTP_W-1:0];
    wire                otp_out = (addr_q[31:OTP_W] != 26'h0);

    // Command class decode
    wire is_prog = (cmd_q == CMD_PROG);
    wire is_sse  = (cmd_q == CMD_SSE);
    wire is_se   = (cmd_q == CMD_SE);
    wire is_die  = (cmd_q == CMD_DIE);
    wire is_pge  = (cmd_q == CMD_PGE);
    wire is_wrsr = (cmd_q == CMD_WRSR);
    wire is_wrlr = (cmd_q == CMD_WRLR);
    wire is_otp  = (cmd_q == CMD_OTP);
    wire is_arr  = is_prog | is_sse | is_se;
    wire is_mod  = is_arr | is_die | is_pge | is_wrsr | is_wrlr | is_otp;
    wire chk     = (state_q == ST_CHECK);
    wire scan    = (state_q == ST_SCAN);

    // Sector under test: the target, or the die scan position
    wire [SECTOR_W-1:0] chk_sector = scan ? {scan_die_q, scan_cnt_q}
                                          : tgt_sec;
    wire rng_prot;
    wire sec_prot = wl_q[chk_sector] | rng_prot;

    fawp_range_dec u_range (
        .top_bottom        (prot_q[4]),
        .protect_size_bit3 (prot_q[3]),
        .protect_size_bit2 (prot_q[2]),
        .protect_size_bit1 (prot_q[1]),
        .protect_size_bit0 (prot_q[0]),
        .sector            (chk_sector),
        .protected_hit     (rng_prot)
    );

    // Verdict, first failing check wins
    wire [3:0] reason =
        !por_done_q                  ? R_POR   :
        (pulses_q[2:0] != 3'h0)      ? R_FRAME :
        !wel_q                       ? R_WEL   :
        is_pge                       ? R_PAGE  :
        ((is_arr | is_die) & tgt_out) ? R_RANGE :
        (is_otp & otp_out)           ? R_RANGE :
        (is_arr & sec_prot)          ? R_PROT  :
        (is_wrlr & ld_q[tgt_sec])    ? R_LOCKD :
        (is_wrsr & wp_low_q)         ? R_WP    :
                                       R_NONE;
    wire refuse_chk = chk & is_mod & (reason != R_NONE);
    wire refuse_scn = scan & sec_prot;
    wire exec_now   = chk & is_mod & (reason == R_NONE) & ~is_die;
    wire die_done   = scan & ~sec_prot & (scan_cnt_q == SCAN_LAST);
    wire issue_arr  = (exec_now & is_arr) | die_done;
    wire modified   = exec_now | die_done;

    // Operation handed to the array engine
    wire [2:0] kind_d = die_done ? K_DIE : is_prog ? K_PROG :
                        is_sse ? K_SSE : K_SE;
    wire [ADDR_W-1:0] oaddr_d =
        die_done ? {scan_die_q, 25'h0} :
        is_sse   ? {addr_q[DIE_BIT:SUBSEC_LSB], 12'h000} :
        is_se    ? {addr_q[DIE_BIT:SECTOR_LSB], 16'h0000} :
                   addr_q[ADDR_W-1:0];
    // Erase drives ones; program passes data the engine ANDs in
    wire [7:0] odata_d = is_prog & ~die_done ? data_q : ERASED_BYTE;

    // Read mux; holes read as zero
    wire [31:0] rd_status = {19'h0, wp_low_q, reason_q, 3'h0,
                             refused_q, ok_q, por_done_q, wel_q,
                             (state_q != ST_IDLE)};
    wire [31:0] rd_mux =
        (avs_address == OFF_ADDR)   ? addr_q :
        (avs_address == OFF_DATA)   ? {24'h0, data_q} :
        (avs_address == OFF_PULSES) ? {16'h0, pulses_q} :
        (avs_address == OFF_CMD)    ? {28'h0, cmd_q} :
        (avs_address == OFF_STATUS) ? rd_status :
        (avs_address == OFF_PROT)   ? {27'h0, prot_q} :
        (avs_address == OFF_LOCKRD) ? {28'h0, tgt_die, tgt_seg,
                                       ld_q[tgt_sec], wl_q[tgt_sec]} :
        (avs_address == OFF_OTPRD)  ? {24'h0, otp_q[otp_idx]} :
                                      32'h0000_0000;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pulse count merged per byte, then narrowed on purpose
    wire [31:0] puls_mrg = be_merge({16'h0, pulses_q}, avs_writedata,
                                    avs_byteenable);

    // Fixed one wait state per access keeps the slave simple
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~(bus_req & wait_q);
            if (avs_read & wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Software-written operands, byte enables honoured
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            addr_q   <= 32'h0000_0000;
            data_q   <= 8'h00;
            pulses_q <= 16'h0000;
        end else begin
            if (wr_addr) begin
                addr_q <= be_merge(addr_q, avs_writedata, avs_byteenable);
            end
            if (wr_data & avs_byteenable[0]) begin
                data_q <= avs_writedata[7:0];
            end
            if (wr_puls) begin
                pulses_q <= puls_mrg[15:0];
            end
        end
    end

    // Sequencer; a command written while busy is dropped
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            cmd_q      <= 4'h0;
            scan_cnt_q <= 9'h000;
            scan_die_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (wr_cmd & avs_byteenable[0]) begin
                        cmd_q   <= avs_writedata[3:0];
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    scan_cnt_q <= 9'h000;
                    scan_die_q <= tgt_die;
                    state_q    <= (is_die & (reason == R_NONE)) ? ST_SCAN
                                                                 : ST_IDLE;
                end
                ST_SCAN: begin
                    // Walk every sector of the die before erasing it
                    scan_cnt_q <= scan_cnt_q + 9'h001;
                    if (refuse_scn | die_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Write enable latch; cleared once a modification runs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wel_q <= 1'b0;
        end else if (chk & (cmd_q == CMD_WREN)) begin
            wel_q <= 1'b1;
        end else if ((chk & (cmd_q == CMD_WRDI)) | modified) begin
            wel_q <= 1'b0;
        end
    end

    // Power-on timer; counts only after reset release
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            por_cnt_q  <= '0;
            por_done_q <= 1'b0;
        end else if (!por_done_q) begin
            por_cnt_q  <= por_cnt_q + POR_W'(1);
            por_done_q <= (por_cnt_q == POR_W'(POR_CYCLES - 1));
        end
    end

    // Pin level accepted once two later stages agree
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wp_s_q   <= 3'h7;
            wp_low_q <= 1'b0;
        end else begin
            wp_s_q <= {wp_s_q[1:0], wp_n};
            if (wp_s_q[1] == wp_s_q[2]) begin
                wp_low_q <= ~wp_s_q[2];
            end
        end
    end

    // Protection state; volatile, so reset unlocks everything
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prot_q <= PROT_RESET;
            wl_q   <= '0;
            ld_q   <= '0;
        end else if (exec_now & is_wrsr) begin
            prot_q <= data_q[4:0];
        end else if (exec_now & is_wrlr) begin
            wl_q[tgt_sec] <= data_q[0];
            ld_q[tgt_sec] <= data_q[1] | ld_q[tgt_sec];
        end
    end

    // One-time area; reset shows the erased state
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < OTP_BYTES; i++) begin
                otp_q[i] <= ERASED_BYTE;
            end
        end else if (exec_now & is_otp) begin
            otp_q[otp_idx] <= otp_q[otp_idx] & data_q;
        end
    end

    // Outcome of the last modifying command
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ok_q      <= 1'b0;
            refused_q <= 1'b0;
            reason_q  <= R_NONE;
        end else if (refuse_chk | refuse_scn) begin
            ok_q      <= 1'b0;
            refused_q <= 1'b1;
            reason_q  <= refuse_scn ? R_PROT : reason;
        end else if (modified) begin
            ok_q      <= 1'b1;
            refused_q <= 1'b0;
            reason_q  <= R_NONE;
        end
    end

    // Array engine request, one-cycle strobe
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            op_valid_q <= 1'b0;
            op_kind_q  <= K_NONE;
            op_addr_q  <= '0;
            op_data_q  <= 8'h00;
        end else begin
            op_valid_q <= issue_arr;
            if (issue_arr) begin
                op_kind_q <= kind_d;
                op_addr_q <= oaddr_d;
                op_data_q <= odata_d;
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign op_valid        = op_valid_q;
    assign op_kind         = op_kind_q;
    assign op_addr         = op_addr_q;
    assign op_data         = op_data_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic             otp_chk_q; // Helper: OTP write just landed
    logic [OTP_W-1:0] otp_ci_q;
    logic [7:0]       otp_ce_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            otp_chk_q <= 1'b0;
            otp_ci_q  <= '0;
            otp_ce_q  <= 8'h00;
        end else begin
            otp_chk_q <= exec_now & is_otp;
            otp_ci_q  <= otp_idx;
            otp_ce_q  <= otp_q[otp_idx] & data_q;
        end
    end

    a_otp_and_only: assert property (
        otp_chk_q |-> (otp_q[otp_ci_q] == otp_ce_q))
        else $error("OTP byte not ANDed with data");
    a_page_no_erase: assert property (
        (chk && is_pge) |=> (!op_valid_q && refused_q))
        else $error("page erase not refused");
    a_subsec_align: assert property (
        (op_valid_q && op_kind_q == K_SSE) |-> (op_addr_q[11:0] == 12'h000))
        else $error("subsector erase misaligned");
    a_frame_discard: assert property (
        (chk && is_mod && pulses_q[2:0] != 3'h0 && por_done_q)
        |=> (reason_q == R_FRAME && !op_valid_q))
        else $error("partial byte command not discarded");
    a_wel_gate: assert property (
        op_valid_q |-> ($past(wel_q) && !wel_q))
        else $error("operation without latch or latch kept");
    a_por_block: assert property (
        op_valid_q |-> $past(por_done_q))
        else $error("operation during power-on");
    a_lock_refuse: assert property (
        (chk && is_arr && wl_q[tgt_sec]) |=> !op_valid_q)
        else $error("locked sector modified");
    a_lockdown_frz: assert property (
        (ld_q[tgt_sec] ##1 $stable(addr_q)) |-> $stable(wl_q[tgt_sec]))
        else $error("frozen lock bit changed");
    a_lock_write_ld: assert property (
        (chk && is_wrlr && ld_q[tgt_sec] && reason == R_LOCKD)
        |=> (refused_q && reason_q == R_LOCKD))
        else $error("lock write while locked down");
    a_top_one: assert property (
        (!prot_q[4] && prot_q[3:0] == 4'h1)
        |-> (rng_prot == (chk_sector == 10'h3FF)))
        else $error("top code 1 range wrong");
    a_bottom_128: assert property (
        (prot_q[4] && prot_q[3:0] == 4'h8)
        |-> (rng_prot == (chk_sector < 10'h080)))
        else $error("bottom code 8 range wrong");
    a_wp_locks: assert property (
        (chk && is_wrsr && wp_low_q) |=> $stable(prot_q))
        else $error("protect bits changed under pin");
    a_range_ignore: assert property (
        (chk && is_arr && rng_prot) |=> !op_valid_q)
        else $error("protected range modified");
    a_die_bound: assert property (
        (state_q == ST_SCAN) |-> ##[1:520] (state_q == ST_IDLE))
        else $error("die scan too long");

    c_die_erase: cover property (op_valid_q && op_kind_q == K_DIE);
    c_prog_issue: cover property (op_valid_q && op_kind_q == K_PROG);
    c_lock_refuse: cover property (refused_q && reason_q == R_PROT);
    c_otp_prog: cover property (otp_chk_q);
endmodule
`default_nettype wire

/* File: flash_array_write_protection_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
 $display("MISMATCH %s exp %0h got %0h", n, e, s); error_cnt++; end end
module flash_array_write_protection_tb_top;
    import fawp_pkg::*;
    logic              sys_clk = 0, resetn = 0, wp_n = 1;
    logic              avs_read = 0, avs_write = 0;
    logic [4:0]        avs_address = 5'h00;
    logic [31:0]       avs_writedata = 32'h0, avs_readdata, rd_q;
    logic [3:0]        avs_byteenable = 4'hF;
    logic              avs_waitrequest, op_valid;
    logic [2:0]        op_kind;
    logic [ADDR_W-1:0] op_addr, a;
    logic [7:0]        op_data, d;
    logic [36:0]       exq [$], lg; // Expected ops, oldest first
    int                error_cnt = 0, num_checks = 0, n, s;
    logic [3:0]        last_why = R_NONE; // Verdict of last modify cmd
    fawp_top #(.POR_CYCLES(40)) u_fawp_top (.sys_clk, .resetn,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .wp_n,
        .op_valid, .op_kind, .op_addr, .op_data);
    fawp_array_model u_fawp_array_model (.sys_clk, .op_valid,
        .op_kind, .op_addr, .op_data);
    initial forever #50 sys_clk = ~sys_clk;
    // Request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] ad,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= ad;
        avs_writedata <= wd;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) error_cnt++;
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Issue a command, poll busy, then judge the refusal reason
    task automatic cmd(input logic [3:0] c, input logic [3:0] why);
        int k;
        k = 0;
        // Latch commands leave the last verdict in place
        if (c == CMD_WREN || c == CMD_WRDI) why = last_why;
        bus(1'b1, OFF_CMD, {28'h0, c});
        bus(1'b0, OFF_STATUS, 32'h0);
        do begin
            bus(1'b0, OFF_STATUS, 32'h0);
            k++;
        end while (rd_q[0] !== 1'b0 && k < 600);
        if (k >= 600) error_cnt++;
        `CHK("reason", why, rd_q[11:8])
        if (c == CMD_WREN || c == CMD_WRDI) begin
            `CHK("wel", c == CMD_WREN, rd_q[1])
        end
        last_why = why;
    endtask
    // Modifying command preceded by WREN; notes the op it must launch
    task automatic mod(input logic [3:0] c, input logic [2:0] k,
        input logic [25:0] ad, input logic [25:0] ea,
        input logic [7:0] wd, input logic [3:0] why);
        bus(1'b1, OFF_ADDR, {6'h0, ad});
        bus(1'b1, OFF_DATA, {24'h0, wd});
        cmd(CMD_WREN, R_NONE);
        if (why === R_NONE && k !== K_NONE)
            exq.push_back({k, ea, (k === K_PROG) ? wd : ERASED_BYTE});
        cmd(c, why);
    endtask
    // Each op pulse is matched against the oldest note
    always @(posedge sys_clk) begin
        if (op_valid === 1'b1) begin
            lg = (exq.size() > 0) ? exq.pop_front() : 37'h0;
            `CHK("op", lg, {op_kind, op_addr, op_data})
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Far longer than the sequence needs
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    initial begin
        void'($urandom(26314));
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        cmd(CMD_WREN, R_NONE);
        cmd(CMD_PROG, R_POR);
        repeat (40) @(posedge sys_clk);
        $display("power-on test done");
        a = 26'($urandom) & 26'h0FFFFFF;
        d = 8'($urandom);
        mod(CMD_PROG, K_PROG, a, a, d, R_NONE);
        `CHK("mem", d, u_fawp_array_model.mem[a])
        cmd(CMD_PROG, R_WEL);
        bus(1'b1, OFF_PULSES, 32'h9);
        mod(CMD_PROG, K_PROG, a, a, d, R_FRAME);
        bus(1'b1, OFF_PULSES, 32'h8);
        mod(CMD_SSE, K_SSE, a, a & 26'h3FFF000, d, R_NONE);
        mod(CMD_SE, K_SE, a, a & 26'h3FF0000, d, R_NONE);
        mod(CMD_PGE, K_NONE, a, a, d, R_PAGE);
        $display("program and erase tests done");
        // Sector 300 gets locked, then frozen
        mod(CMD_WRLR, K_NONE, 26'h12C0000, 0, 8'h01, R_NONE);
        mod(CMD_PROG, K_PROG, 26'h12C0005, 0, d, R_PROT);
        mod(CMD_WRLR, K_NONE, 26'h12C0000, 0, 8'h03, R_NONE);
        mod(CMD_WRLR, K_NONE, 26'h12C0000, 0, 8'h00, R_LOCKD);
        bus(1'b0, OFF_LOCKRD, 32'h0);
        `CHK("lockrd", 4'h7, rd_q[3:0])
        $display("lock tests done");
        // Probe each code at the edge of its protected range
        for (int tb = 0; tb < 2; tb++) begin
            for (int c = 0; c < 16; c++) begin
                mod(CMD_WRSR, K_NONE, 0, 0, 8'(tb * 16 + c), R_NONE);
                n = (c == 0) ? 0 : (c > 10) ? 1024 : 1 << (c - 1);
                s = tb ? n - 1 : 1024 - n;
                a = 26'(s) << 16;
                if (n > 0)
                    mod(CMD_PROG, K_PROG, a, a, d, R_PROT);
                s = tb ? n : 1023 - n;
                a = 26'(s) << 16;
                if (n < 1024)
                    mod(CMD_PROG, K_PROG, a, a, d, R_NONE);
            end
        end
        wp_n <= 1'b0;
        mod(CMD_WRSR, K_NONE, 0, 0, 8'h00, R_WP);
        bus(1'b0, OFF_PROT, 32'h0);
        `CHK("prot", 5'h1F, rd_q[4:0])
        wp_n <= 1'b1;
        mod(CMD_WRSR, K_NONE, 0, 0, 8'h00, R_NONE);
        $display("range tests done");
        mod(CMD_OTP, K_NONE, 26'h5, 0, 8'h5A, R_NONE);
        bus(1'b0, OFF_OTPRD, 32'h0);
        `CHK("otp", 8'h5A, rd_q[7:0])
        mod(CMD_OTP, K_NONE, 26'h40, 0, 8'h00, R_RANGE);
        bus(1'b1, OFF_ADDR, 32'h0400_0000);
        cmd(CMD_WREN, R_NONE);
        cmd(CMD_SE, R_RANGE);
        cmd(CMD_WRDI, R_NONE);
        cmd(CMD_SE, R_WEL);
        mod(CMD_DIE, K_DIE, 26'h2000000, 26'h2000000, d, R_NONE);
        mod(CMD_DIE, K_DIE, 26'h0, 26'h0, d, R_PROT);
        `CHK("leftover", 0, exq.size())
        $display("die erase tests done");
        stop_test();
    end
endmodule
`default_nettype wire
